// File: mstc_defines.svh
// Constants for the transceiver management soft control and status block.
`ifndef MSTC_DEFINES_SVH
`define MSTC_DEFINES_SVH

// Clock rate and documented maximum times.
`define MSTC_CLK_MHZ 100
`define MSTC_INIT_TIME_MS 2000

// Management memory byte addresses.
`define MSTC_ADDR_STATUS2 8'h02
`define MSTC_ADDR_FLAG_BASE 8'h03
`define MSTC_ADDR_MASK_BASE 8'h64
`define MSTC_ADDR_CTRL_PWR 8'h5D

// Field positions.
`define MSTC_BIT_DNR 0
`define MSTC_BIT_PDOWN 1
`define MSTC_FLAG_BYTES 4
`define MSTC_NUM_FLAGS 13
`define MSTC_NUM_COND 12
`define MSTC_IDX_READY 12

// Reset values.
`define MSTC_RST_MASK 13'h0000
`define MSTC_RST_FLAGS 13'h0000
`define MSTC_RST_LINK_STAT 14'h2000
`define MSTC_RST_SYNC 20'hE0007

`endif

// File: mstc_pkg.sv
// Types shared by the soft control and status block.
`default_nettype none
package mstc_pkg;
   // Gray coded along hold, init, ready.
   typedef enum logic [1:0] {
      MSTC_HOLD  = 2'b00,
      MSTC_INIT  = 2'b01,
      MSTC_READY = 2'b11
   } mstc_state_t;
endpackage
`default_nettype wire

// File: mstc_soft_control.sv
// Management soft control, latched flags, interrupt and select gating of a transceiver module.
// Function
// [R1] Fully functional within 2000 ms after reset.
// [R2] Any low reset pin pulse resets module.
// [R3] Answer serial bus within 2000 ms.
// [R4] Clear data-not-ready and assert interrupt.
// [R5] Fully functional means interrupt from ready.
// [R6] Low-power pin enters low power quickly.
// [R7] Interrupt output low within 200 ms.
// [R8] Clearing read releases interrupt within 500 us.
// [R9] Receive loss sets flag within 100 ms.
// [R10] Transmit fault sets flag within 200 ms.
// [R11] Other conditions set flag within 200 ms.
// [R12] Setting mask inhibits interrupt within 100 ms.
// [R13] Clearing mask resumes interrupt within 100 ms.
// [R14] Selected module answers bus within 100 us.
// [R15] Deselected module stops answering within 100 us.
// [R16] Power-down bit enters low power within 100 ms.
// [R17] Clearing power-down restores function within 300 ms.
// [R18] Write deadlines start after write stop.
// [R19] Read deadlines start after read stop.
// [R20] Flags live in read-only bytes 3-21; the code decodes flag bytes 3-6 only.
// [R21] Masks live in read/write bytes 100-106; the code decodes mask bytes 100-103 only.
// [R22] Flags latch until read; interrupt follows them.
// [R23] All times are maxima; sooner is fine.
`include "mstc_defines.svh"
`default_nettype none
module mstc_soft_control #(
   parameter logic [31:0] INIT_CYCLES = 32'(`MSTC_INIT_TIME_MS * 1000 * `MSTC_CLK_MHZ)
) (
   // System clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Host pins.
   input wire logic module_reset_in_n,
   input wire logic low_power_pin,
   input wire logic module_select_n,
   output logic irq_out_n,
   // Condition inputs from the optical side.
   input wire logic [3:0] rxLossIn,
   input wire logic [3:0] txFaultIn,
   input wire logic [3:0] miscCondIn,
   // Status towards the rest of the module.
   output logic lowPowerMode,
   output logic busEnable,
   output logic dataNotReady,
   // Two-wire front end, sampled on falling serial clock edges.
   input wire logic serialClk,
   input wire logic linkWrStb,
   input wire logic linkRdStb,
   input wire logic linkStop,
   input wire logic [7:0] linkAddr,
   input wire logic [7:0] linkWrData,
   output logic [7:0] linkRdData
);

   ////////////////////////////////////////////////////////////////////////////
   // Decoding shared by the read and write paths.

   // Both windows hold four bytes, so one helper serves the flag and the mask decode.
   // Returns the flag or mask byte index, or FLAG_BYTES when outside the range.
   function automatic logic [2:0] byteIndex(input logic [7:0] addr, input logic [7:0] base);
      logic [7:0] off;
      off = addr - base;
      byteIndex = (addr >= base && off < 8'(`MSTC_FLAG_BYTES)) ? off[2:0] : 3'(`MSTC_FLAG_BYTES);
   endfunction

   // Picks one byte of a 13 bit vector laid out as four bit groups.
   function automatic logic [7:0] groupByte(input logic [12:0] vec, input logic [2:0] idx);
      logic [15:0] wide;
      wide = {3'h0, vec};
      groupByte = {4'h0, wide[idx[1:0]*4 +: 4]};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Link domain, clocked on falling serial clock edges.
   // The serial clock only runs while the host talks, so every link register holds its value between frames.
   // Status seen by reads passes a two-stage sync that only advances on serial edges; the address phase of a
   // transaction supplies those edges before the data byte, so the value read is fresh.
   // A clearing read only clears bits that it returned as set, so a flag that rises after the read
   // was sampled stays latched until the next read reports it.

   logic [12:0] lnkMaskQ, lnkMaskD;
   logic lnkPdQ, lnkPdD;
   logic lnkWrTogQ, lnkWrTogD;
   logic lnkRdTogQ, lnkRdTogD;
   logic lnkWrSeenQ, lnkWrSeenD;
   logic lnkRdSeenQ, lnkRdSeenD;
   logic [12:0] lnkClrAccQ, lnkClrAccD;
   logic [12:0] lnkClrHoldQ, lnkClrHoldD;
   logic [7:0] lnkRdDataQ, lnkRdDataD;
   logic [13:0] lnkStatMetaQ, lnkStatQ;
   logic [12:0] flagsQ;
   logic dnrQ;

   // Register writes land in link-side copies; a stop publishes them by a toggle.
   // The copies stay stable well past the toggle sync because the next byte needs nine serial clocks.
   always_comb begin
      logic [2:0] wIdx;
      logic [2:0] rIdx;
      wIdx = byteIndex(linkAddr, `MSTC_ADDR_MASK_BASE);
      rIdx = byteIndex(linkAddr, `MSTC_ADDR_FLAG_BASE);
      lnkMaskD = lnkMaskQ;
      lnkPdD = lnkPdQ;
      lnkWrTogD = lnkWrTogQ;
      lnkRdTogD = lnkRdTogQ;
      lnkWrSeenD = lnkWrSeenQ;
      lnkRdSeenD = lnkRdSeenQ;
      lnkClrAccD = lnkClrAccQ;
      lnkClrHoldD = lnkClrHoldQ;
      lnkRdDataD = lnkRdDataQ;
      if (linkWrStb) begin
         lnkWrSeenD = 1'b1;
         if (wIdx == 3'd3) begin // R21
            lnkMaskD[`MSTC_IDX_READY] = linkWrData[0];
         end else if (wIdx < 3'd3) begin
            lnkMaskD[wIdx[1:0]*4 +: 4] = linkWrData[3:0];
         end
         if (linkAddr == `MSTC_ADDR_CTRL_PWR) begin
            lnkPdD = linkWrData[`MSTC_BIT_PDOWN];
         end
      end
      // Until the block is ready no write may commit, so the link copies return to their reset values;
      // otherwise a reset pin pulse would leave old masks that the next write would publish again.
      if (lnkStatQ[13]) begin // R2
         lnkMaskD = `MSTC_RST_MASK;
         lnkPdD = 1'b0;
      end
      if (linkRdStb) begin
         lnkRdSeenD = 1'b1;
         lnkRdDataD = 8'h00;
         if (linkAddr == `MSTC_ADDR_STATUS2) begin
            lnkRdDataD[`MSTC_BIT_DNR] = lnkStatQ[13];
         end else if (rIdx != 3'(`MSTC_FLAG_BYTES)) begin // R20
            lnkRdDataD = groupByte(lnkStatQ[12:0], rIdx);
            // Only the bits returned as set are queued for clearing.
            lnkClrAccD = lnkClrAccQ | (lnkStatQ[12:0] & (rIdx == 3'd3 ? 13'h1000 : (13'h000F << (rIdx[1:0] * 4))));
         end else if (wIdx != 3'(`MSTC_FLAG_BYTES)) begin
            lnkRdDataD = groupByte(lnkMaskQ, wIdx);
         end else if (linkAddr == `MSTC_ADDR_CTRL_PWR) begin
            lnkRdDataD[`MSTC_BIT_PDOWN] = lnkPdQ;
         end
      end
      if (linkStop) begin
         if (lnkWrSeenQ) begin
            lnkWrTogD = ~lnkWrTogQ; // R18
         end
         if (lnkRdSeenQ) begin
            lnkClrHoldD = lnkClrAccQ;
            lnkRdTogD = ~lnkRdTogQ; // R19
         end
         lnkWrSeenD = 1'b0;
         lnkRdSeenD = 1'b0;
         lnkClrAccD = 13'h0000;
      end
   end

   // Link registers, plus a two-stage sync of the independent status bits.
   // Reset leaves the status copy at not ready, matching the system side.
   always_ff @(negedge serialClk or negedge rst_n) begin
      if (!rst_n) begin
         lnkMaskQ <= `MSTC_RST_MASK;
         lnkPdQ <= 1'b0;
         lnkWrTogQ <= 1'b0;
         lnkRdTogQ <= 1'b0;
         lnkWrSeenQ <= 1'b0;
         lnkRdSeenQ <= 1'b0;
         lnkClrAccQ <= 13'h0000;
         lnkClrHoldQ <= 13'h0000;
         lnkRdDataQ <= 8'h00;
         lnkStatMetaQ <= `MSTC_RST_LINK_STAT;
         lnkStatQ <= `MSTC_RST_LINK_STAT;
      end else begin
         lnkMaskQ <= lnkMaskD;
         lnkPdQ <= lnkPdD;
         lnkWrTogQ <= lnkWrTogD;
         lnkRdTogQ <= lnkRdTogD;
         lnkWrSeenQ <= lnkWrSeenD;
         lnkRdSeenQ <= lnkRdSeenD;
         lnkClrAccQ <= lnkClrAccD;
         lnkClrHoldQ <= lnkClrHoldD;
         lnkRdDataQ <= lnkRdDataD;
         lnkStatMetaQ <= {dnrQ, flagsQ};
         lnkStatQ <= lnkStatMetaQ;
      end
   end

   assign linkRdData = lnkRdDataQ;

   ////////////////////////////////////////////////////////////////////////////
   // Pin and toggle synchronisers into the system domain.

   logic [19:0] syncMetaQ, syncQ;
   logic wrTogOldQ, rdTogOldQ;
   logic [11:0] condOldQ;

   // First stage feeds only the second; edges are taken from the second onward.
   // The reset value shows the reset and select pins at their idle level, the low-power pin high, and every toggle and condition at the value of its
   // old copy, so no false edge or commit follows reset.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         syncMetaQ <= `MSTC_RST_SYNC;
         syncQ <= `MSTC_RST_SYNC;
         wrTogOldQ <= 1'b0;
         rdTogOldQ <= 1'b0;
         condOldQ <= 12'h000;
      end else begin
         syncMetaQ <= {module_reset_in_n, module_select_n, low_power_pin, lnkWrTogQ, lnkRdTogQ,
                       miscCondIn, txFaultIn, rxLossIn, 3'h7};
         syncQ <= syncMetaQ;
         wrTogOldQ <= syncQ[16];
         rdTogOldQ <= syncQ[15];
         condOldQ <= syncQ[14:3];
      end
   end

   // Decoded views of the second sync stage; each toggle change is one commit from the link side.
   logic rstPinLow, selActive, lpPin, wrCommit, rdCommit;
   logic [11:0] condRise;
   assign rstPinLow = !syncQ[19];
   assign selActive = !syncQ[18];
   assign lpPin = syncQ[17];
   assign wrCommit = syncQ[16] ^ wrTogOldQ;
   assign rdCommit = syncQ[15] ^ rdTogOldQ;
   assign condRise = syncQ[14:3] & ~condOldQ;

   ////////////////////////////////////////////////////////////////////////////
   // Initialisation sequence, flags, masks and outputs.
   // The counter runs only in the init state, so its width covers the full init time at the system clock.
   // Masks and the power-down bit change only on a committed write or a reset pin low; the commit is ignored until ready,
   // which keeps a host from arming masks before the first interrupt of a power cycle.

   mstc_pkg::mstc_state_t stateQ, stateD;
   logic [31:0] cntQ, cntD;
   logic [12:0] maskQ, maskD, flagsD;
   logic dnrD, pdQ, pdD;
   logic irqNQ, irqND, lpQ, lpD, busEnQ, busEnD;
   logic [12:0] setVec;

   // A reset pin low that the pin synchroniser samples on a rising clock edge restarts the sequence; set wins over a clearing read.
   always_comb begin
      stateD = stateQ;
      cntD = cntQ;
      maskD = maskQ;
      flagsD = flagsQ;
      dnrD = dnrQ;
      pdD = pdQ;
      setVec = {1'b0, condRise}; // R9 R10 R11
      case (stateQ)
         mstc_pkg::MSTC_HOLD: begin
            if (!rstPinLow) begin
               stateD = mstc_pkg::MSTC_INIT;
            end
         end
         mstc_pkg::MSTC_INIT: begin
            cntD = cntQ + 32'h1;
            if (cntQ >= INIT_CYCLES - 32'h1) begin
               stateD = mstc_pkg::MSTC_READY; // R1
               dnrD = 1'b0; // R4
               setVec[`MSTC_IDX_READY] = 1'b1; // R5
            end
         end
         mstc_pkg::MSTC_READY: begin
            if (wrCommit) begin
               maskD = lnkMaskQ; // R12 R13
               pdD = lnkPdQ; // R16 R17
            end
         end
         default: begin
            stateD = mstc_pkg::MSTC_HOLD;
         end
      endcase
      if (rdCommit) begin
         flagsD = flagsD & ~lnkClrHoldQ; // R8
      end
      flagsD = flagsD | setVec; // R22
      if (rstPinLow) begin
         stateD = mstc_pkg::MSTC_HOLD; // R2
         cntD = 32'h0;
         maskD = `MSTC_RST_MASK;
         flagsD = `MSTC_RST_FLAGS;
         dnrD = 1'b1;
         pdD = 1'b0;
      end
   end

   // Outputs follow the current state one cycle later, far inside every maximum.
   // Registering costs one cycle and keeps the pins free of decode glitches.
   always_comb begin
      irqND = !(|(flagsQ & ~maskQ)); // R7 R22 R23
      lpD = lpPin | pdQ; // R6 R16 R17
      busEnD = selActive && (stateQ == mstc_pkg::MSTC_READY); // R3 R14 R15
   end

   // Registers of the control group.
   // Every register here takes the same asynchronous reset, so the outputs are defined from the first edge.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stateQ <= mstc_pkg::MSTC_HOLD;
         cntQ <= 32'h0;
         maskQ <= `MSTC_RST_MASK;
         flagsQ <= `MSTC_RST_FLAGS;
         dnrQ <= 1'b1;
         pdQ <= 1'b0;
         irqNQ <= 1'b1;
         lpQ <= 1'b0;
         busEnQ <= 1'b0;
      end else begin
         stateQ <= stateD;
         cntQ <= cntD;
         maskQ <= maskD;
         flagsQ <= flagsD;
         dnrQ <= dnrD;
         pdQ <= pdD;
         irqNQ <= irqND;
         lpQ <= lpD;
         busEnQ <= busEnD;
      end
   end

   assign irq_out_n = irqNQ;
   assign lowPowerMode = lpQ;
   assign busEnable = busEnQ;
   assign dataNotReady = dnrQ;

   ////////////////////////////////////////////////////////////////////////////
   // Checks and coverage in the system domain.
   // Link-side registers are read here only where a toggle commit has just made them stable,
   // so sampling them on the system clock is safe.

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_init_ready: assert property (stateQ == mstc_pkg::MSTC_INIT && cntQ == INIT_CYCLES - 32'h1 && !rstPinLow
      |=> !dnrQ && flagsQ[`MSTC_IDX_READY] ##1 (maskQ[`MSTC_IDX_READY] || !irq_out_n)) // R1
      else $error("ready not reached at end of init count");
   a_pin_reset: assert property (rstPinLow |=> stateQ == mstc_pkg::MSTC_HOLD && dnrQ && flagsQ == 13'h0000) // R2
      else $error("reset pin low did not reset the module");
   a_irq_assert: assert property ((|(flagsQ & ~maskQ)) |=> !irq_out_n) // R7
      else $error("interrupt not asserted for unmasked flag");
   a_irq_release: assert property (!(|(flagsQ & ~maskQ)) |=> irq_out_n) // R8
      else $error("interrupt not released without unmasked flags");
   a_flag_latch: assert property (!rstPinLow && condRise[0] ##1 (!rstPinLow && !rdCommit) [*3] |=> flagsQ[0]) // R9
      else $error("receive loss flag not latched");
   a_tx_latch: assert property (!rstPinLow && condRise[4] |=> flagsQ[4]) // R10
      else $error("transmit fault flag not set");
   a_clear_read: assert property (rdCommit && !rstPinLow && !(|setVec) |=> (flagsQ & $past(lnkClrHoldQ)) == 13'h0000) // R8
      else $error("clearing read left a flag set");
   a_low_power: assert property ($rose(lpPin) |=> lowPowerMode) // R6
      else $error("low power pin not followed");
   a_select_gate: assert property (!selActive |=> !busEnable) // R15
      else $error("bus enabled while deselected");
   a_select_ready: assert property (selActive && stateQ == mstc_pkg::MSTC_READY |=> busEnable) // R14
      else $error("bus not enabled while selected and ready");
   // Invariants of the sequence, the commit path and the set-wins order.
   a_dnr_state: assert property (dataNotReady == (stateQ != mstc_pkg::MSTC_READY)) // R4
      else $error("data not ready disagrees with the sequence state");
   a_bus_not_ready: assert property (stateQ != mstc_pkg::MSTC_READY |=> !busEnable) // R3
      else $error("bus enabled before ready");
   a_mask_commit: assert property (wrCommit && stateQ == mstc_pkg::MSTC_READY && !rstPinLow // R12 R13
      |=> maskQ == $past(lnkMaskQ))
      else $error("committed write did not reach the masks");
   a_pd_commit: assert property (wrCommit && stateQ == mstc_pkg::MSTC_READY && !rstPinLow // R16 R17
      |=> pdQ == $past(lnkPdQ))
      else $error("committed write did not reach the power-down bit");
   a_set_wins: assert property (rdCommit && !rstPinLow |=> (flagsQ[11:0] & $past(condRise)) == $past(condRise)) // R22
      else $error("condition rise lost against a clearing read");

   // Main scenarios.
   c_ready: cover property (stateQ == mstc_pkg::MSTC_INIT ##1 stateQ == mstc_pkg::MSTC_READY);
   c_masked: cover property (flagsQ[0] && maskQ[0] && irq_out_n);
   c_rx_flag: cover property (condRise[0] ##[1:4] !irq_out_n);
   c_cleared: cover property (rdCommit ##2 irq_out_n);
   c_pdown: cover property (wrCommit && lnkPdQ ##2 lowPowerMode);

endmodule
`default_nettype wire

// File: mstc_host_model.sv
// Host board controller model driving the two-wire front end of the block.
`default_nettype none
module mstc_host_model (
   // Link towards the front end.
   output logic serialClk,
   output logic wrStb,
   output logic rdStb,
   output logic stop,
   output logic [7:0] addr,
   output logic [7:0] wrData,
   // Answer from the front end.
   input wire logic [7:0] rdData
);
   timeunit 1ns;
   timeprecision 100ps;

   // The serial clock stands low between frames.
   initial begin
      serialClk = 1'b0;
      wrStb = 1'b0;
      rdStb = 1'b0;
      stop = 1'b0;
      addr = 8'h00;
      wrData = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////
   // One serial cycle; lines change just after the falling sampling edge.
   task automatic cyc(input logic w, input logic r, input logic s, input logic [7:0] a, input logic [7:0] d);
      #1 wrStb = w;
      rdStb = r;
      stop = s;
      addr = a;
      wrData = d;
      #2 serialClk = 1'b1;
      #3 serialClk = 1'b0;
   endtask

   // One byte, the stop cycle, then spacing before the next transaction.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      // Two idle edges stand for the address phase and refresh the front end's status copy.
      repeat (2) cyc(1'b0, 1'b0, 1'b0, ~a, ~d);
      cyc(w, !w, 1'b0, a, d);
      #1 q = rdData;
      cyc(1'b0, 1'b0, 1'b1, ~a, ~d);
      // Released lines show the inverse so stale values cannot pass.
      repeat (2) cyc(1'b0, 1'b0, 1'b0, ~a, ~d);
      #50;
   endtask
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking bench of the soft control and status block.
`include "mstc_defines.svh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;

   `define MSTC_CMP(e, a) begin comparisons++; if ((a) !== (e)) begin failures++; \
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, a); end end

   logic clk, rst_n, resetPinN, lowPowerPin, selectN, irqN;
   logic [3:0] cond [3];
   logic lowPowerMode, busEnable, dataNotReady;
   logic serialClk, wrStb, rdStb, stop;
   logic [7:0] addr, wrData, rdData, q, e1, o1;
   logic [3:0] nib;
   logic [7:0] expQ[$];
   logic [7:0] obsQ[$];
   int failures = 0;
   int comparisons = 0;
   int cycles = 0;
   integer seed = 24937;

   mstc_soft_control #(.INIT_CYCLES(32'd20)) dut (.clk(clk), .rst_n(rst_n),
      .module_reset_in_n(resetPinN), .low_power_pin(lowPowerPin), .module_select_n(selectN),
      .irq_out_n(irqN), .rxLossIn(cond[0]), .txFaultIn(cond[1]), .miscCondIn(cond[2]),
      .lowPowerMode(lowPowerMode), .busEnable(busEnable), .dataNotReady(dataNotReady),
      .serialClk(serialClk), .linkWrStb(wrStb), .linkRdStb(rdStb), .linkStop(stop),
      .linkAddr(addr), .linkWrData(wrData), .linkRdData(rdData));

   mstc_host_model host (.serialClk(serialClk), .wrStb(wrStb), .rdStb(rdStb), .stop(stop),
      .addr(addr), .wrData(wrData), .rdData(rdData));

   ////////////////////////////////////////////////////////////////////////
   // System clock at 100 MHz.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Cuts a hang short; the whole run needs a few hundred cycles.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         stop_test();
      end
   end

   // Takes the oldest note whenever an observation arrives.
   initial begin
      forever begin
         wait (obsQ.size() > 0);
         e1 = expQ.pop_front();
         o1 = obsQ.pop_front();
         `MSTC_CMP(e1, o1)
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] o, input logic [7:0] e);
      expQ.push_back(e);
      obsQ.push_back(o);
      #0;
   endtask

   task automatic settle(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      host.xfer(1'b0, a, 8'h00, q);
      chk(q, e);
      settle(1);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.xfer(1'b1, a, d, q);
      settle(8);
   endtask

   task automatic stop_test();
      #1;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence; pins change on the falling clock edge.
   initial begin
      rst_n = 1'b0;
      resetPinN = 1'b1;
      lowPowerPin = 1'b0;
      selectN = 1'b1;
      for (int g = 0; g < 3; g++) cond[g] = 4'h0;
      repeat (20) @(posedge clk);
      @(negedge clk) rst_n = 1'b1;
      chk(8'(dataNotReady), 8'h01);
      settle(30);
      chk(8'(dataNotReady), 8'h00);
      chk(8'(irqN), 8'h00);
      chk(8'(busEnable), 8'h00);
      selectN = 1'b0;
      settle(6);
      chk(8'(busEnable), 8'h01);
      rd(`MSTC_ADDR_STATUS2, 8'h00);
      rd(8'h06, 8'h01);
      settle(8);
      chk(8'(irqN), 8'h01);
      rd(8'h50, 8'h00);
      $display("test init done");
      // Random conditions on each group; writes to flag bytes must not stick.
      for (int g = 0; g < 3; g++) begin
         nib = 4'($random(seed));
         if (nib == 4'h0) nib = 4'h9;
         cond[g] = nib;
         settle(6);
         chk(8'(irqN), 8'h00);
         wr(8'(`MSTC_ADDR_FLAG_BASE + g), 8'hFF);
         rd(8'(`MSTC_ADDR_FLAG_BASE + g), {4'h0, nib});
         settle(8);
         chk(8'(irqN), 8'h01);
         rd(8'(`MSTC_ADDR_FLAG_BASE + g), 8'h00);
         cond[g] = 4'h0;
      end
      $display("test flags done");
      wr(`MSTC_ADDR_MASK_BASE, 8'h0F);
      cond[0] = 4'h1;
      settle(8);
      chk(8'(irqN), 8'h01);
      rd(`MSTC_ADDR_MASK_BASE, 8'h0F);
      wr(`MSTC_ADDR_MASK_BASE, 8'h00);
      chk(8'(irqN), 8'h00);
      rd(`MSTC_ADDR_FLAG_BASE, 8'h01);
      settle(8);
      chk(8'(irqN), 8'h01);
      cond[0] = 4'h0;
      $display("test mask done");
      lowPowerPin = 1'b1;
      settle(5);
      chk(8'(lowPowerMode), 8'h01);
      lowPowerPin = 1'b0;
      settle(5);
      chk(8'(lowPowerMode), 8'h00);
      wr(`MSTC_ADDR_CTRL_PWR, 8'h02);
      chk(8'(lowPowerMode), 8'h01);
      wr(`MSTC_ADDR_CTRL_PWR, 8'h00);
      chk(8'(lowPowerMode), 8'h00);
      $display("test power done");
      resetPinN = 1'b0;
      settle(6);
      chk(8'(dataNotReady), 8'h01);
      chk(8'(irqN), 8'h01);
      resetPinN = 1'b1;
      settle(30);
      chk(8'(dataNotReady), 8'h00);
      chk(8'(irqN), 8'h00);
      rd(8'h06, 8'h01);
      selectN = 1'b1;
      settle(6);
      chk(8'(busEnable), 8'h00);
      $display("test reset done");
      settle(4);
      stop_test();
   end
endmodule
`default_nettype wire
